/* File: verilog/imd_regs.svh */
`ifndef IMD_REGS_SVH
`define IMD_REGS_SVH
`define IMD_HIGH_BANK  4'hf
`define IMD_LOW_BANK   4'h0
`define IMD_SHORT_FAR_CALL_LO   16'h0800
`define IMD_SHORT_FAR_CALL_HI   16'h0fff
`define IMD_PERIPHERAL_RAM_REGION_HI    16'hfcff
`define IMD_FAST_INTERNAL_RAM_LO    16'hfd00
`define IMD_FAST_INTERNAL_RAM_HI    16'hfeff
`define IMD_SHORT_LO   16'hfd20
`define IMD_GPR_LO     16'hfe80
`define IMD_MSCW_LO    16'hfe06
`define IMD_MSCW_HI    16'hfe39
`define IMD_MSCW_GAP0  15'h7f11
`define IMD_MSCW_GAP1  15'h7f15
`define IMD_MSCW_GAP2  15'h7f18
`define IMD_SFR_LO     16'hff00
`define IMD_XSFR_LO    16'hffd0
`define IMD_XSFR_HI    16'hffdf
`define IMD_SIZE_OFS   16'hfffc
`define IMD_SIZE_RST   8'hff
`define IMD_ROM_MSB    5
`define IMD_ROM_LSB    4
`define IMD_RAM_MSB    1
`define IMD_RAM_LSB    0
`define IMD_RAM_BASE0  16'hd600
`define IMD_RAM_BASE1  16'heb00
`define IMD_RAM_BASE2  16'he500
`define IMD_RAM_BASE3  16'hdf00
`define IMD_ROM_TOP0   20'h40000
`define IMD_ROM_TOP1   20'h18000
`define IMD_ROM_TOP2   20'h20000
`define IMD_ROM_TOP3   20'h30000
`define IMD_PERIPHERAL_RAM_REGION_FETCH_CLKS 2
`endif

/* File: verilog/imd_pkg.sv */
package imd_pkg;
  typedef logic [19:0] imd_addr_t;
  typedef logic [1:0]  imd_size_t;
  typedef enum logic [2:0] {
    rg_none, rg_rom, rg_peripheral_ram_region, rg_fast_internal_ram, rg_sfr, rg_xsfr, rg_ext
  } imd_region_e;
  typedef enum logic [1:0] {st_idle, st_wait, st_hung} imd_state_e;
endpackage : imd_pkg

/* File: verilog/imd_dec_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface imd_dec_if;
  import imd_pkg::*;
  imd_addr_t   addr;
  logic        loc_high;
  imd_size_t   rom_sel;
  imd_size_t   ram_sel;
  logic        ext_en;
  imd_region_e region;
  logic        short_far_call;
  logic        short_ok;
  logic        gpr;
  logic        mscw;
  modport dec (input addr, loc_high, rom_sel, ram_sel, ext_en,
               output region, short_far_call, short_ok, gpr, mscw);
  modport top (output addr, loc_high, rom_sel, ram_sel, ext_en,
               input region, short_far_call, short_ok, gpr, mscw);
endinterface : imd_dec_if
`default_nettype wire

/* File: verilog/imd_region_dec.sv */
`timescale 1ns/1ns
`default_nettype none
`include "imd_regs.svh"
module imd_region_dec
  import imd_pkg::*;
(
  imd_dec_if.dec d
);
  logic [15:0] lo;
  logic        in_bank;
  logic [15:0] ram_base;
  imd_addr_t   rom_top;

  assign lo      = d.addr[15:0];
  // data area sits in bank 0 or bank f
  assign in_bank = d.addr[19:16] == (d.loc_high ? `IMD_HIGH_BANK : `IMD_LOW_BANK);

  always_comb begin
    case (d.ram_sel)
      2'h0:    ram_base = `IMD_RAM_BASE0;
      2'h1:    ram_base = `IMD_RAM_BASE1;
      2'h2:    ram_base = `IMD_RAM_BASE2;
      default: ram_base = `IMD_RAM_BASE3;
    endcase
    case (d.rom_sel)
      2'h0:    rom_top = `IMD_ROM_TOP0;
      2'h1:    rom_top = `IMD_ROM_TOP1;
      2'h2:    rom_top = `IMD_ROM_TOP2;
      default: rom_top = `IMD_ROM_TOP3;
    endcase
  end

  // one select per address, data area checked first
  always_comb begin
    if (in_bank && lo >= `IMD_SFR_LO) begin
      if (d.ext_en && lo >= `IMD_XSFR_LO && lo <= `IMD_XSFR_HI)
        d.region = rg_xsfr;
      else
        d.region = rg_sfr;
    end else if (in_bank && lo >= `IMD_FAST_INTERNAL_RAM_LO && lo <= `IMD_FAST_INTERNAL_RAM_HI) begin
      d.region = rg_fast_internal_ram;
    end else if (in_bank && lo >= ram_base && lo <= `IMD_PERIPHERAL_RAM_REGION_HI) begin
      d.region = rg_peripheral_ram_region;
    end else if (d.addr < rom_top) begin
      d.region = rg_rom;
    end else if (d.ext_en) begin
      d.region = rg_ext;
    end else begin
      d.region = rg_none;
    end
  end

  assign d.short_far_call    = d.addr[19:16] == 4'h0 && lo >= `IMD_SHORT_FAR_CALL_LO
                      && lo <= `IMD_SHORT_FAR_CALL_HI;
  assign d.short_ok = in_bank && lo >= `IMD_SHORT_LO && lo <= `IMD_FAST_INTERNAL_RAM_HI;
  assign d.gpr      = in_bank && lo >= `IMD_GPR_LO && lo <= `IMD_FAST_INTERNAL_RAM_HI;
  assign d.mscw     = in_bank && lo >= `IMD_MSCW_LO && lo <= `IMD_MSCW_HI
                      && lo[15:1] != `IMD_MSCW_GAP0 && lo[15:1] != `IMD_MSCW_GAP1
                      && lo[15:1] != `IMD_MSCW_GAP2;
endmodule : imd_region_dec
`default_nettype wire

/* File: verilog/imd_memory_map.sv */
`timescale 1ns/1ns
`default_nettype none
`include "imd_regs.svh"
// Summary of operation
// - decode 00800H..00FFFH as the short far call entry region
// - data area ends at 0FFFFH low placement, top of 1 MB high placement
// - placement taken once after reset, later selections ignored until reset
// - data area wins over any other region at the same address
// - fast RAM 0FD00H..0FEFFH, peripheral RAM from RAM base to 0FCFFH
// - high placement relocates RAM and special registers by 0F0000H
// - short direct addressing reaches only FD20H..FEFFH
// - FE80H..FEFFH reserved for general register banks
// - FE06H..FE39H macro service words, except pairs FE22H, FE2AH, FE30H
// - peripheral RAM fetch gives one byte every two clocks
// - 0FF00H..0FFFFH is the special register space
// - unpopulated special register access hangs until reset
// - expansion mode routes 0FFD0H..0FFDFH to the external bus
// - external special register cycles look like external memory cycles
// - external space reachable only as expansion mode allows
// - memory size select resets to FFH, written by byte operations
// - bits 5:4 pick ROM size 256, 96, 128 or 192 KB
// - bits 1:0 pick RAM size 10496, 5120, 6656 or 8192 bytes
module imd_memory_map
  import imd_pkg::*;
#(
  parameter logic [255:0] SFR_POPULATED = {256{1'b1}}
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // placement selection
  input  wire logic        loc_req,
  input  wire logic        loc_high,
  // expansion mode register setting
  input  wire logic        ext_en,
  // cpu access request
  input  wire logic        acc_req,
  input  wire imd_addr_t   acc_addr,
  input  wire logic        acc_write,
  input  wire logic        acc_byte,
  input  wire logic        acc_fetch,
  input  wire logic        acc_short,
  input  wire logic [7:0]  acc_wdata,
  // access answer
  output logic             acc_ready,
  output logic             ans_valid,
  output imd_region_e      ans_region,
  output logic [7:0]       ans_rdata,
  output logic             ext_cycle,
  output logic             short_far_call_hit,
  output logic             gpr_hit,
  output logic             mscw_hit,
  output logic             short_err,
  output logic             fetch_err,
  // configuration state
  output logic             loc_done,
  output logic             loc_is_high,
  output logic [7:0]       mem_size_sel,
  output logic             hung
);
  // ****************************************
  // decode
  // ****************************************
  imd_dec_if dif ();
  imd_region_dec u_dec (.d(dif));

  logic      loc_done_reg, loc_done_next;
  logic      loc_high_reg, loc_high_next;
  imd_size_t rom_sel_reg, rom_sel_next;
  imd_size_t ram_sel_reg, ram_sel_next;

  assign dif.addr     = acc_addr;
  assign dif.loc_high = loc_high_reg;
  assign dif.rom_sel  = rom_sel_reg;
  assign dif.ram_sel  = ram_sel_reg;
  assign dif.ext_en   = ext_en;

  logic take;
  logic size_hit;
  logic unpop;
  logic peripheral_ram_region_fetch;

  assign take       = clk_en && acc_req && acc_ready;
  assign size_hit   = dif.region == rg_sfr && acc_addr[15:0] == `IMD_SIZE_OFS;
  assign unpop      = dif.region == rg_sfr && !SFR_POPULATED[acc_addr[7:0]];
  assign peripheral_ram_region_fetch = acc_fetch && dif.region == rg_peripheral_ram_region;

  // ****************************************
  // configuration
  // ****************************************
  always_comb begin
    loc_done_next = loc_done_reg;
    loc_high_next = loc_high_reg;
    rom_sel_next  = rom_sel_reg;
    ram_sel_next  = ram_sel_reg;
    if (clk_en && loc_req && !loc_done_reg) begin
      loc_done_next = 1'b1;
      loc_high_next = loc_high;
    end
    if (take && acc_write && acc_byte && size_hit) begin
      rom_sel_next = acc_wdata[`IMD_ROM_MSB:`IMD_ROM_LSB];
      ram_sel_next = acc_wdata[`IMD_RAM_MSB:`IMD_RAM_LSB];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loc_done_reg <= 1'b0;
      loc_high_reg <= 1'b0;
      rom_sel_reg  <= 2'(`IMD_SIZE_RST >> `IMD_ROM_LSB);
      ram_sel_reg  <= 2'(`IMD_SIZE_RST >> `IMD_RAM_LSB);
    end else begin
      loc_done_reg <= loc_done_next;
      loc_high_reg <= loc_high_next;
      rom_sel_reg  <= rom_sel_next;
      ram_sel_reg  <= ram_sel_next;
    end
  end

  // ****************************************
  // access sequencing
  // ****************************************
  imd_state_e  state_reg, state_next;
  logic        ready_reg, ready_next;
  logic        ans_reg, ans_next;
  imd_region_e region_reg, region_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        ext_reg, ext_next;
  logic        short_far_call_reg, short_far_call_next;
  logic        gpr_reg, gpr_next;
  logic        mscw_reg, mscw_next;
  logic        serr_reg, serr_next;
  logic        ferr_reg, ferr_next;
  logic        hung_reg, hung_next;

  always_comb begin
    state_next  = state_reg;
    ready_next  = ready_reg;
    ans_next    = 1'b0;
    region_next = region_reg;
    rdata_next  = rdata_reg;
    ext_next    = ext_reg;
    short_far_call_next  = short_far_call_reg;
    gpr_next    = gpr_reg;
    mscw_next   = mscw_reg;
    serr_next   = serr_reg;
    ferr_next   = ferr_reg;
    if (!clk_en) begin
      ans_next = ans_reg;
    end else begin
      case (state_reg)
        st_idle: begin
          if (take) begin
            region_next = dif.region;
            ext_next    = dif.region == rg_ext || dif.region == rg_xsfr;
            short_far_call_next  = dif.short_far_call;
            gpr_next    = dif.gpr;
            mscw_next   = dif.mscw;
            serr_next   = acc_short && !dif.short_ok;
            ferr_next   = acc_fetch && (dif.region == rg_fast_internal_ram
                          || dif.region == rg_sfr);
            rdata_next  = 8'h00;
            if (!acc_write && size_hit)
              rdata_next = {2'b11, rom_sel_reg, 2'b11, ram_sel_reg};
            if (unpop) begin
              state_next = st_hung;
              ready_next = 1'b0;
            end else if (peripheral_ram_region_fetch) begin
              state_next = st_wait;
              ready_next = 1'b0;
            end else begin
              ans_next = 1'b1;
            end
          end
        end
        st_wait: begin
          state_next = st_idle;
          ready_next = 1'b1;
          ans_next   = 1'b1;
        end
        st_hung: begin
          state_next = st_hung;
          ready_next = 1'b0;
        end
        default: begin
          state_next = st_idle;
          ready_next = 1'b1;
        end
      endcase
    end
    hung_next = state_next == st_hung;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= st_idle;
      ready_reg  <= 1'b1;
      ans_reg    <= 1'b0;
      region_reg <= rg_none;
      rdata_reg  <= 8'h00;
      ext_reg    <= 1'b0;
      short_far_call_reg  <= 1'b0;
      gpr_reg    <= 1'b0;
      mscw_reg   <= 1'b0;
      serr_reg   <= 1'b0;
      ferr_reg   <= 1'b0;
      hung_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      ready_reg  <= ready_next;
      ans_reg    <= ans_next;
      region_reg <= region_next;
      rdata_reg  <= rdata_next;
      ext_reg    <= ext_next;
      short_far_call_reg  <= short_far_call_next;
      gpr_reg    <= gpr_next;
      mscw_reg   <= mscw_next;
      serr_reg   <= serr_next;
      ferr_reg   <= ferr_next;
      hung_reg   <= hung_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign acc_ready    = ready_reg;
  assign ans_valid    = ans_reg;
  assign ans_region   = region_reg;
  assign ans_rdata    = rdata_reg;
  assign ext_cycle    = ext_reg;
  assign short_far_call_hit    = short_far_call_reg;
  assign gpr_hit      = gpr_reg;
  assign mscw_hit     = mscw_reg;
  assign short_err    = serr_reg;
  assign fetch_err    = ferr_reg;
  assign loc_done     = loc_done_reg;
  assign loc_is_high  = loc_high_reg;
  assign mem_size_sel = {2'b11, rom_sel_reg, 2'b11, ram_sel_reg};
  assign hung         = hung_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence peripheral_ram_region_fetch_taken;
    take && peripheral_ram_region_fetch;
  endsequence
  sequence peripheral_ram_region_answer;
    state_reg == st_wait && !ans_reg && clk_en ##1 ans_reg && state_reg == st_idle;
  endsequence
  sequence size_byte_write;
    take && acc_write && acc_byte && size_hit;
  endsequence

  // access lands in the data bank of the chosen placement
  logic chk_bank;
  assign chk_bank = acc_addr[19:16] == (loc_high_reg ? `IMD_HIGH_BANK : `IMD_LOW_BANK);

  loc_once_a: assert property (
    loc_done_reg && clk_en && loc_req |=> $stable(loc_high_reg))
    else $error("placement changed after first selection");
  loc_first_a: assert property (
    !loc_done_reg && clk_en && loc_req |=> loc_done_reg && loc_high_reg == $past(loc_high))
    else $error("first placement not taken");
  high_reloc_a: assert property (
    take && loc_high_reg && acc_addr >= 20'hffd00 && acc_addr <= 20'hffeff
    |=> region_reg == rg_fast_internal_ram)
    else $error("relocated fast ram not decoded");
  fast_internal_ram_prio_a: assert property (
    take && !loc_high_reg && acc_addr >= 20'h0fd00 && acc_addr <= 20'h0feff
    |=> region_reg == rg_fast_internal_ram)
    else $error("fast ram not decoded over rom");
  sfr_space_a: assert property (
    take && acc_addr[19:16] == (loc_high_reg ? 4'hf : 4'h0) && acc_addr[15:8] == 8'hff
    |=> region_reg == rg_sfr || region_reg == rg_xsfr)
    else $error("special register space miss");
  xsfr_route_a: assert property (
    take && ext_en && dif.region == rg_xsfr |=> ext_reg && region_reg == rg_xsfr)
    else $error("external register window not routed");
  ext_gate_a: assert property (
    take && !ext_en |=> !ext_reg)
    else $error("external cycle without expansion mode");
  short_far_call_area_a: assert property (
    take && acc_addr >= 20'h00800 && acc_addr <= 20'h00fff |=> short_far_call_reg)
    else $error("short far call area not flagged");
  short_range_a: assert property (
    take && acc_short && acc_addr[15:0] < 16'hfd20 |=> serr_reg)
    else $error("short access below fd20 allowed");
  peripheral_ram_region_pace_a: assert property (
    peripheral_ram_region_fetch_taken ##1 clk_en |-> peripheral_ram_region_answer)
    else $error("peripheral ram fetch pacing wrong");
  hang_hold_a: assert property (
    state_reg == st_hung |=> state_reg == st_hung && !ready_reg && !ans_reg)
    else $error("hang released without reset");
  size_write_a: assert property (
    take && acc_write && acc_byte && size_hit
    |=> mem_size_sel[5:4] == $past(acc_wdata[5:4]) && mem_size_sel[1:0] == $past(acc_wdata[1:0]))
    else $error("size select write lost");
  size_word_a: assert property (
    take && acc_write && !acc_byte |=> $stable(mem_size_sel))
    else $error("size select changed by word write");

  // ****************************************
  // decode and freeze checks
  // ****************************************
  freeze_hold_a: assert property (
    !clk_en |=> $stable(state_reg) && $stable(region_reg) && $stable(mem_size_sel))
    else $error("state moved while clock enable low");
  peripheral_ram_region_stall_a: assert property (
    peripheral_ram_region_fetch_taken |=> !ready_reg)
    else $error("peripheral ram fetch did not stall");
  gpr_area_a: assert property (
    take && chk_bank && acc_addr[15:0] >= 16'hfe80 && acc_addr[15:0] <= 16'hfeff |=> gpr_reg)
    else $error("register bank area not flagged");
  mscw_hole_a: assert property (
    take && chk_bank && acc_addr[15:1] == 15'h7f11 |=> !mscw_reg)
    else $error("macro word hole flagged");
  mscw_area_a: assert property (
    take && chk_bank && acc_addr[15:0] == 16'hfe06 |=> mscw_reg)
    else $error("macro word area not flagged");
  fetch_guard_a: assert property (
    take && acc_fetch && dif.region == rg_fast_internal_ram |=> ferr_reg)
    else $error("fast ram fetch not flagged");
  peripheral_ram_region_top_a: assert property (
    take && chk_bank && acc_addr[15:0] == 16'hfcff |=> region_reg == rg_peripheral_ram_region)
    else $error("peripheral ram top not decoded");
  low_top_a: assert property (
    take && !loc_high_reg && acc_addr == 20'h0ffff |=> region_reg == rg_sfr)
    else $error("low data area end not decoded");
  xsfr_off_a: assert property (
    take && !ext_en && chk_bank && acc_addr[15:4] == 12'hffd |=> region_reg == rg_sfr)
    else $error("external register window routed without expansion");
  unpop_hang_a: assert property (
    take && unpop |=> state_reg == st_hung && !ready_reg)
    else $error("unpopulated register access did not hang");
  ans_next_a: assert property (
    take && !unpop && !peripheral_ram_region_fetch |=> ans_reg)
    else $error("answer missing one cycle after take");
  size_fixed_a: assert property (
    size_byte_write |=> mem_size_sel[7:6] == 2'b11 && mem_size_sel[3:2] == 2'b11)
    else $error("fixed size select bits not one");
endmodule : imd_memory_map
`default_nettype wire

/* File: bench/imd_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// cpu side access model
// ****************************************
module imd_cpu_model
  import imd_pkg::*;
(
  // clock and answer
  input  wire logic       clk,
  input  wire logic       acc_ready,
  input  wire logic       ans_valid,
  // request
  output logic            acc_req,
  output imd_addr_t       acc_addr,
  output logic            acc_write,
  output logic            acc_byte,
  output logic            acc_fetch,
  output logic            acc_short,
  output logic [7:0]      acc_wdata
);
  initial begin
    {acc_req, acc_addr, acc_write, acc_byte, acc_fetch, acc_short, acc_wdata} = '0;
  end

  // wfbs = {write, fetch, byte, short}; lat = cycles from take to answer, 4 = none
  task automatic access(input imd_addr_t a, input logic [3:0] wfbs, input logic [7:0] wd,
                        output int lat);
    int n;
    n = 0;
    @(negedge clk);
    acc_req = 1'b1;
    acc_addr = a;
    {acc_write, acc_fetch, acc_byte, acc_short} = wfbs;
    acc_fetch = wfbs[2] && !(a[15:8] inside {8'hfd, 8'hfe});
    acc_wdata = wd;
    while (acc_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    acc_req = 1'b0;
    lat = 0;
    while (ans_valid !== 1'b1 && lat < 4) begin
      @(negedge clk);
      lat++;
    end
  endtask : access
endmodule : imd_cpu_model
`default_nettype wire

/* File: bench/imd_memory_map_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// memory map decoder bench
// ****************************************
module imd_memory_map_tb_top;
  import imd_pkg::*;
  // one unpopulated special register byte at offset 80
  localparam logic [255:0] SFR_MAP = ~(256'h1 << 8'h80);
  logic        clk, resetn, clk_en, loc_req, loc_high, ext_en, hi;
  logic        acc_req, acc_write, acc_byte, acc_fetch, acc_short, acc_ready, ans_valid;
  logic        ext_cycle, short_far_call_hit, gpr_hit, mscw_hit, short_err, fetch_err;
  logic        loc_done, loc_is_high, hung;
  imd_addr_t   acc_addr;
  imd_region_e ans_region;
  logic [7:0]  acc_wdata, ans_rdata, mem_size_sel, sz;
  int          fails, checks_done, cycles, lat, seed;
  logic [15:0] ram_base [4] = '{16'hd600, 16'heb00, 16'he500, 16'hdf00};
  logic [19:0] rom_top  [4] = '{20'h40000, 20'h18000, 20'h20000, 20'h30000};
  logic [7:0]  szv      [5] = '{8'hdd, 8'hee, 8'hff, 8'hcc, 8'h31};
  logic [19:0] corner   [] = '{20'h007ff, 20'h00800, 20'h00fff, 20'h01000, 20'h0d5ff,
    20'h0d600, 20'h0deff, 20'h0df00, 20'h0e4ff, 20'h0e500, 20'h0eaff, 20'h0eb00, 20'h0fcff,
    20'h0fd00, 20'h0fd1f, 20'h0fd20, 20'h0fe05, 20'h0fe06, 20'h0fe22, 20'h0fe23, 20'h0fe24,
    20'h0fe39, 20'h0fe3a, 20'h0fe7f, 20'h0fe80, 20'h0feff, 20'h0ff00, 20'h0ffcf, 20'h0ffd0,
    20'h0ffdf, 20'h0ffe0, 20'h0fffc, 20'h17fff, 20'h18000, 20'h1ffff, 20'h20000, 20'h2ffff,
    20'h30000, 20'h3ffff, 20'h40000};

  imd_memory_map #(.SFR_POPULATED(SFR_MAP)) DUT (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .loc_req(loc_req), .loc_high(loc_high),
    .ext_en(ext_en), .acc_req(acc_req), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_byte(acc_byte), .acc_fetch(acc_fetch), .acc_short(acc_short),
    .acc_wdata(acc_wdata), .acc_ready(acc_ready), .ans_valid(ans_valid),
    .ans_region(ans_region), .ans_rdata(ans_rdata), .ext_cycle(ext_cycle),
    .short_far_call_hit(short_far_call_hit), .gpr_hit(gpr_hit), .mscw_hit(mscw_hit), .short_err(short_err),
    .fetch_err(fetch_err), .loc_done(loc_done), .loc_is_high(loc_is_high),
    .mem_size_sel(mem_size_sel), .hung(hung));

  imd_cpu_model u_cpu (
    .clk(clk), .acc_ready(acc_ready), .ans_valid(ans_valid), .acc_req(acc_req),
    .acc_addr(acc_addr), .acc_write(acc_write), .acc_byte(acc_byte),
    .acc_fetch(acc_fetch), .acc_short(acc_short), .acc_wdata(acc_wdata));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // region that the placement, size field and expansion mode give
  function automatic imd_region_e exp_rg(input imd_addr_t a, input logic e);
    logic bk;
    bk = a[19:16] == {4{hi}};
    if (bk && a[15:4] == 12'hffd && e) return rg_xsfr;
    if (bk && a[15:8] == 8'hff) return rg_sfr;
    if (bk && a[15:0] >= 16'hfd00) return rg_fast_internal_ram;
    if (bk && a[15:0] >= ram_base[sz[1:0]]) return rg_peripheral_ram_region;
    if (a < rom_top[sz[5:4]]) return rg_rom;
    return e ? rg_ext : rg_none;
  endfunction : exp_rg

  task automatic probe(input imd_addr_t a);
    logic [31:0] r;
    logic [15:0] lo;
    logic        bk;
    logic        e;
    r = $random(seed);
    if (a[15:0] == 16'hff80) a[0] = 1'b1;
    lo = a[15:0];
    bk = a[19:16] == {4{hi}};
    e = r[0];
    ext_en = e;
    u_cpu.access(a, {3'b001, r[1]}, 8'h00, lat);
    chk(lat, 0);
    chk(ans_region, exp_rg(a, e));
    chk(ext_cycle, exp_rg(a, e) inside {rg_ext, rg_xsfr});
    chk(short_far_call_hit, a >= 20'h00800 && a <= 20'h00fff);
    chk(gpr_hit, bk && lo >= 16'hfe80 && lo <= 16'hfeff);
    chk(mscw_hit, bk && lo >= 16'hfe06 && lo <= 16'hfe39
        && !(lo[15:1] inside {15'h7f11, 15'h7f15, 15'h7f18}));
    chk(short_err, r[1] && !(bk && lo >= 16'hfd20 && lo <= 16'hfeff));
  endtask : probe

  task automatic run(input logic h);
    logic [31:0] rnd;
    hi = h;
    sz = 8'hff;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk(hung, 1'b0);
    chk(mem_size_sel, 8'hff);
    resetn = 1'b1;
    chk(loc_done, 1'b0);
    loc_req = 1'b1;
    loc_high = h;
    @(negedge clk);
    loc_high = !h;
    @(negedge clk);
    loc_req = 1'b0;
    chk(loc_is_high, h);
    clk_en = 1'b0;
    u_cpu.access({{4{h}}, 16'hfffc}, 4'b1010, 8'h00, lat);
    chk(lat, 4);
    chk(mem_size_sel, 8'hff);
    clk_en = 1'b1;
    foreach (szv[i]) begin
      u_cpu.access({{4{h}}, 16'hfffc}, 4'b1010, szv[i], lat);
      sz = szv[i] | 8'hcc;
      chk(mem_size_sel, sz);
      u_cpu.access({{4{h}}, 16'hfffc}, 4'b1000, 8'h00, lat);
      chk(mem_size_sel, sz);
      u_cpu.access({{4{h}}, 16'hfffc}, 4'b0010, 8'h00, lat);
      chk(ans_rdata, sz);
      u_cpu.access({{4{h}}, 16'hfcfe}, 4'b0100, 8'h00, lat);
      chk(lat, 1);
      chk(ans_region, rg_peripheral_ram_region);
      foreach (corner[j]) begin
        probe(corner[j]);
        probe(corner[j] | {h, h, h, h, 16'h0});
      end
      repeat (40) begin
        rnd = $random(seed);
        probe({rnd[20] ? {{4{h}}, 4'hf} : rnd[19:12], rnd[11:0]});
      end
    end
  endtask : run

  initial begin
    clk = 1'b0;
    seed = 32'hbd682829;
    {resetn, clk_en, loc_req, loc_high, ext_en} = 5'b01000;
    {fails, checks_done, cycles, lat} = '0;
    run(1'b0);
    run(1'b1);
    u_cpu.access({4'hf, 16'hff80}, 4'b0010, 8'h00, lat);
    chk(lat, 4);
    chk(hung, 1'b1);
    run(1'b0);
    conclude();
  end
endmodule : imd_memory_map_tb_top
`default_nettype wire
